// file: rtl/mic_pkg.sv
package mic_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TIMER_RUN_OVERFLOW_CONTROL = 8'h88;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE_MAIN      = 8'ha8;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_MAIN    = 8'hb8;
  localparam logic [7:0] ADDR_INTERRUPT_ENABLE_KERNEL    = 8'he8;
  localparam logic [7:0] ADDR_INTERRUPT_PRIORITY_KERNEL  = 8'hf8;

  localparam logic [7:0] REG_RESET = 8'h00;

  // writable bits; all others read zero
  localparam logic [7:0] MASK_TIMER_CONTROL  = 8'hf0;
  localparam logic [7:0] MASK_ENABLE_MAIN    = 8'hba;
  localparam logic [7:0] MASK_PRIORITY_MAIN  = 8'h3a;
  localparam logic [7:0] MASK_KERNEL         = 8'h01;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int BIT_GLOBAL_IRQ_GATE   = 7;
  localparam int BIT_TIMER_ZERO        = 1;
  localparam int BIT_TIMER_ONE         = 3;
  localparam int BIT_SERIAL_PORT       = 4;
  localparam int BIT_MERGED_INTERNAL   = 5;
  localparam int BIT_KERNEL            = 0;
  localparam int BIT_TIMER_ZERO_RUN    = 4;
  localparam int BIT_TIMER_ZERO_OVF    = 5;
  localparam int BIT_TIMER_ONE_RUN     = 6;
  localparam int BIT_TIMER_ONE_OVF     = 7;

  // ----------------------------------------------------------------
  // sources in polling order, lowest index polled first
  // ----------------------------------------------------------------
  localparam int NUM_SRC          = 5;
  localparam int NUM_INTERNAL     = 8;
  localparam logic [2:0] SRC_T0   = 3'h0;
  localparam logic [2:0] SRC_T1   = 3'h1;
  localparam logic [2:0] SRC_UART = 3'h2;
  localparam logic [2:0] SRC_MERGED_INTERNAL_REQUEST = 3'h3;
  localparam logic [2:0] SRC_RTK  = 3'h4;

  // ----------------------------------------------------------------
  // vectors
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_RESET      = 16'h2000;
  localparam logic [15:0] VEC_PIN_ZERO   = 16'h2003;
  localparam logic [15:0] VEC_TIMER_ZERO = 16'h200b;
  localparam logic [15:0] VEC_PIN_ONE    = 16'h2013;
  localparam logic [15:0] VEC_TIMER_ONE  = 16'h201b;
  localparam logic [15:0] VEC_UART       = 16'h2023;
  localparam logic [15:0] VEC_MERGED     = 16'h202b;
  localparam logic [15:0] VEC_KERNEL     = 16'h2033;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         MERGED_ENTRY_INSTR_CYCLES = 8;
  localparam int         CLKS_PER_INSTR_CYCLE      = 1;
  localparam logic [3:0] MERGED_ENTRY_CLKS         =
    4'(MERGED_ENTRY_INSTR_CYCLES * CLKS_PER_INSTR_CYCLE);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } mic_sfr_req_s;

  typedef enum {
    MIC_IDLE,
    MIC_WAIT,
    MIC_REQ
  } mic_state_e;

  function automatic logic [15:0] mic_vector(input logic [2:0] idx);
    logic [15:0] v;
    v = VEC_RESET;
    unique case (idx)
      SRC_T0:   v = VEC_TIMER_ZERO;
      SRC_T1:   v = VEC_TIMER_ONE;
      SRC_UART: v = VEC_UART;
      SRC_MERGED_INTERNAL_REQUEST: v = VEC_MERGED;
      SRC_RTK:  v = VEC_KERNEL;
      default:  v = VEC_RESET;
    endcase
    return v;
  endfunction

endpackage

// file: rtl/mic_prio_pick.sv
`timescale 1ns/1ps
module mic_prio_pick
  import mic_pkg::*;
(
  input  wire logic [NUM_SRC-1:0] i_req,
  input  wire logic [NUM_SRC-1:0] i_prio,
  input  wire logic               i_hi_active,
  input  wire logic               i_lo_active,
  output logic                    o_valid,
  output logic [2:0]              o_idx,
  output logic                    o_is_hi
);

  // ----------------------------------------------------------------
  // fixed polling, high level first
  // ----------------------------------------------------------------
  logic       hi_found;
  logic       lo_found;
  logic [2:0] hi_idx;
  logic [2:0] lo_idx;

  always_comb
  begin
    hi_found = 1'b0;
    lo_found = 1'b0;
    hi_idx   = SRC_T0;
    lo_idx   = SRC_T0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (i_req[i] && i_prio[i])
      begin
        hi_found = 1'b1;
        hi_idx   = 3'(i);
      end
      if (i_req[i] && !i_prio[i])
      begin
        lo_found = 1'b1;
        lo_idx   = 3'(i);
      end
    end
  end

  always_comb
  begin
    o_valid = 1'b0;
    o_idx   = hi_idx;
    o_is_hi = 1'b1;
    if (hi_found && !i_hi_active)
    begin
      o_valid = 1'b1;
    end
    else if (lo_found && !i_hi_active && !i_lo_active)
    begin
      o_valid = 1'b1;
      o_idx   = lo_idx;
      o_is_hi = 1'b0;
    end
  end

endmodule

// file: rtl/mic_entry_delay.sv
`timescale 1ns/1ps
module mic_entry_delay
  import mic_pkg::*;
(
  input  wire logic i_clk,
  input  wire logic i_resetn,
  input  wire logic i_ce,
  input  wire logic i_clear,
  input  wire logic i_start,
  output logic      o_done
);

  // ----------------------------------------------------------------
  // extra entry cycles for the merged request
  // ----------------------------------------------------------------
  logic [3:0] count;

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      count <= 4'h0;
    end
    else if (i_ce)
    begin
      if (i_clear)
      begin
        count <= 4'h0;
      end
      else if (i_start)
      begin
        count <= MERGED_ENTRY_CLKS;
      end
      else if (count != 4'h0)
      begin
        count <= count - 4'h1;
      end
    end
  end

  assign o_done = (count == 4'h1);

endmodule

// file: rtl/mic_core.sv
`timescale 1ns/1ps
// Overview of operation
// - no pin interrupts; their vectors never entered
// - all internal sources ORed into merged request
// - kernel interrupt served at vector 0x2033
// - timer and serial vectors remapped to 0x20xx
// - merged entry waits eight extra instruction cycles
// - firmware start at 0x2000 after download
// - registers clear on resets, usb if connected
// - enable bit 7 gates every interrupt
// - main enable bits 1,3,4,5 and 7; others zero
// - main priority bits 1,3,4,5; one high
// - kernel enable bit 0; rest read zero
// - kernel priority bit 0; rest read zero
// - timer run bits 4 and 6
// - overflow flags set by hardware, cleared on entry
// - timer control low nibble reads zero
// - merged request level sensitive, active low
module mic_core
(
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire logic                  i_ce,
  input  wire mic_pkg::mic_sfr_req_s i_sfr,
  output logic [7:0]                 o_sfr_rdata,
  input  wire logic                  i_usb_reset,
  input  wire logic                  i_function_reset_connect,
  input  wire logic                  i_download_done,
  input  wire logic                  i_timer_zero_ovf,
  input  wire logic                  i_timer_one_ovf,
  input  wire logic                  i_uart_req,
  input  wire logic [7:0]            i_internal_src,
  input  wire logic                  i_kernel_req,
  input  wire logic                  i_irq_ack,
  input  wire logic                  i_reti,
  output logic                       o_irq_req,
  output logic [15:0]                o_irq_vector,
  output logic                       o_fw_start,
  output logic                       o_timer_zero_run,
  output logic                       o_timer_one_run,
  output logic                       o_merged_internal_request_n
);
  import mic_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0]         timer_run_overflow_control;
  logic [7:0]         interrupt_enable_main;
  logic [7:0]         interrupt_priority_main;
  logic [7:0]         interrupt_enable_kernel;
  logic [7:0]         interrupt_priority_kernel;
  logic               timer_zero_overflow_flag;
  logic               timer_one_overflow_flag;
  logic               soft_clear;
  logic               wr_timer_run_overflow_control;
  logic               wr_ie;
  logic               wr_ip;
  logic               wr_ie1;
  logic               wr_ip1;
  logic               merged_internal_request;
  logic [NUM_SRC-1:0] src_pend;
  logic [NUM_SRC-1:0] src_en;
  logic [NUM_SRC-1:0] src_prio;
  logic [NUM_SRC-1:0] src_req;
  logic               pick_valid;
  logic [2:0]         pick_idx;
  logic               pick_hi;
  mic_state_e         state;
  logic [2:0]         sel_idx;
  logic               sel_hi;
  logic               hi_active;
  logic               lo_active;
  logic               started;
  logic               delay_start;
  logic               delay_done;
  logic               entry_t0;
  logic               entry_t1;
  logic [7:0]         read_mux;

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign soft_clear = i_usb_reset && i_function_reset_connect;
  assign wr_timer_run_overflow_control    = i_sfr.wr && (i_sfr.addr == ADDR_TIMER_RUN_OVERFLOW_CONTROL);
  assign wr_ie      = i_sfr.wr && (i_sfr.addr == ADDR_INTERRUPT_ENABLE_MAIN);
  assign wr_ip      = i_sfr.wr && (i_sfr.addr == ADDR_INTERRUPT_PRIORITY_MAIN);
  assign wr_ie1     = i_sfr.wr && (i_sfr.addr == ADDR_INTERRUPT_ENABLE_KERNEL);
  assign wr_ip1     = i_sfr.wr && (i_sfr.addr == ADDR_INTERRUPT_PRIORITY_KERNEL);

  // ----------------------------------------------------------------
  // enable and priority registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      interrupt_enable_main     <= REG_RESET;
      interrupt_priority_main   <= REG_RESET;
      interrupt_enable_kernel   <= REG_RESET;
      interrupt_priority_kernel <= REG_RESET;
    end
    else if (i_ce)
    begin
      if (soft_clear)
      begin
        interrupt_enable_main     <= REG_RESET;
        interrupt_priority_main   <= REG_RESET;
        interrupt_enable_kernel   <= REG_RESET;
        interrupt_priority_kernel <= REG_RESET;
      end
      else
      begin
        if (wr_ie)
          interrupt_enable_main <= i_sfr.wdata & MASK_ENABLE_MAIN;
        if (wr_ip)
          interrupt_priority_main <= i_sfr.wdata & MASK_PRIORITY_MAIN;
        if (wr_ie1)
          interrupt_enable_kernel <= i_sfr.wdata & MASK_KERNEL;
        if (wr_ip1)
          interrupt_priority_kernel <= i_sfr.wdata & MASK_KERNEL;
      end
    end
  end

  // ----------------------------------------------------------------
  // timer run bits
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timer_run_overflow_control <= REG_RESET;
    end
    else if (i_ce)
    begin
      if (soft_clear)
        timer_run_overflow_control <= REG_RESET;
      else if (wr_timer_run_overflow_control)
        timer_run_overflow_control <= i_sfr.wdata & MASK_TIMER_CONTROL;
    end
  end

  // ----------------------------------------------------------------
  // overflow flags: set wins over entry clear and register write
  // ----------------------------------------------------------------
  assign entry_t0 = (state == MIC_REQ) && i_irq_ack && (sel_idx == SRC_T0);
  assign entry_t1 = (state == MIC_REQ) && i_irq_ack && (sel_idx == SRC_T1);

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      timer_zero_overflow_flag <= 1'b0;
      timer_one_overflow_flag  <= 1'b0;
    end
    else if (i_ce)
    begin
      if (soft_clear)
      begin
        timer_zero_overflow_flag <= 1'b0;
        timer_one_overflow_flag  <= 1'b0;
      end
      else
      begin
        if (i_timer_zero_ovf)
          timer_zero_overflow_flag <= 1'b1;
        else if (entry_t0)
          timer_zero_overflow_flag <= 1'b0;
        else if (wr_timer_run_overflow_control)
          timer_zero_overflow_flag <= i_sfr.wdata[BIT_TIMER_ZERO_OVF];
        if (i_timer_one_ovf)
          timer_one_overflow_flag <= 1'b1;
        else if (entry_t1)
          timer_one_overflow_flag <= 1'b0;
        else if (wr_timer_run_overflow_control)
          timer_one_overflow_flag <= i_sfr.wdata[BIT_TIMER_ONE_OVF];
      end
    end
  end

  // ----------------------------------------------------------------
  // source collection
  // ----------------------------------------------------------------
  assign merged_internal_request = |i_internal_src;

  always_comb
  begin
    src_pend           = '0;
    src_en             = '0;
    src_prio           = '0;
    src_pend[SRC_T0]   = timer_zero_overflow_flag;
    src_pend[SRC_T1]   = timer_one_overflow_flag;
    src_pend[SRC_UART] = i_uart_req;
    src_pend[SRC_MERGED_INTERNAL_REQUEST] = merged_internal_request;
    src_pend[SRC_RTK]  = i_kernel_req;
    src_en[SRC_T0]     = interrupt_enable_main[BIT_TIMER_ZERO];
    src_en[SRC_T1]     = interrupt_enable_main[BIT_TIMER_ONE];
    src_en[SRC_UART]   = interrupt_enable_main[BIT_SERIAL_PORT];
    src_en[SRC_MERGED_INTERNAL_REQUEST]   = interrupt_enable_main[BIT_MERGED_INTERNAL];
    src_en[SRC_RTK]    = interrupt_enable_kernel[BIT_KERNEL];
    src_prio[SRC_T0]   = interrupt_priority_main[BIT_TIMER_ZERO];
    src_prio[SRC_T1]   = interrupt_priority_main[BIT_TIMER_ONE];
    src_prio[SRC_UART] = interrupt_priority_main[BIT_SERIAL_PORT];
    src_prio[SRC_MERGED_INTERNAL_REQUEST] = interrupt_priority_main[BIT_MERGED_INTERNAL];
    src_prio[SRC_RTK]  = interrupt_priority_kernel[BIT_KERNEL];
  end

  // global gate over every source
  assign src_req = src_pend & src_en
                   & {NUM_SRC{interrupt_enable_main[BIT_GLOBAL_IRQ_GATE]}};

  mic_prio_pick u_pick
  (
    .i_req       (src_req),
    .i_prio      (src_prio),
    .i_hi_active (hi_active),
    .i_lo_active (lo_active),
    .o_valid     (pick_valid),
    .o_idx       (pick_idx),
    .o_is_hi     (pick_hi)
  );

  // ----------------------------------------------------------------
  // merged entry delay
  // ----------------------------------------------------------------
  assign delay_start = (state == MIC_IDLE) && started && pick_valid
                       && (pick_idx == SRC_MERGED_INTERNAL_REQUEST);

  mic_entry_delay u_delay
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_ce     (i_ce),
    .i_clear  (soft_clear),
    .i_start  (delay_start),
    .o_done   (delay_done)
  );

  // ----------------------------------------------------------------
  // entry sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state        <= MIC_IDLE;
      sel_idx      <= SRC_T0;
      sel_hi       <= 1'b0;
      started      <= 1'b0;
      o_irq_req    <= 1'b0;
      o_irq_vector <= VEC_RESET;
      o_fw_start   <= 1'b0;
    end
    else if (i_ce)
    begin
      o_fw_start <= 1'b0;
      if (soft_clear)
      begin
        state     <= MIC_IDLE;
        o_irq_req <= 1'b0;
      end
      else
      begin
        unique case (state)
          MIC_IDLE:
          begin
            if (!started && i_download_done)
            begin
              started      <= 1'b1;
              o_fw_start   <= 1'b1;
              o_irq_vector <= VEC_RESET;
            end
            else if (started && pick_valid)
            begin
              sel_idx <= pick_idx;
              sel_hi  <= pick_hi;
              if (pick_idx == SRC_MERGED_INTERNAL_REQUEST)
              begin
                state <= MIC_WAIT;
              end
              else
              begin
                state        <= MIC_REQ;
                o_irq_req    <= 1'b1;
                o_irq_vector <= mic_vector(pick_idx);
              end
            end
          end
          MIC_WAIT:
          begin
            if (delay_done)
            begin
              state        <= MIC_REQ;
              o_irq_req    <= 1'b1;
              o_irq_vector <= VEC_MERGED;
            end
          end
          MIC_REQ:
          begin
            if (i_irq_ack)
            begin
              state     <= MIC_IDLE;
              o_irq_req <= 1'b0;
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // in-service levels
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      hi_active <= 1'b0;
      lo_active <= 1'b0;
    end
    else if (i_ce)
    begin
      if (soft_clear)
      begin
        hi_active <= 1'b0;
        lo_active <= 1'b0;
      end
      else if ((state == MIC_REQ) && i_irq_ack)
      begin
        if (sel_hi)
          hi_active <= 1'b1;
        else
          lo_active <= 1'b1;
      end
      else if (i_reti)
      begin
        if (hi_active)
          hi_active <= 1'b0;
        else
          lo_active <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs and read path
  // ----------------------------------------------------------------
  always_comb
  begin
    read_mux = 8'h00;
    unique case (i_sfr.addr)
      ADDR_TIMER_RUN_OVERFLOW_CONTROL:
      begin
        read_mux                     = timer_run_overflow_control;
        read_mux[BIT_TIMER_ZERO_OVF] = timer_zero_overflow_flag;
        read_mux[BIT_TIMER_ONE_OVF]  = timer_one_overflow_flag;
      end
      ADDR_INTERRUPT_ENABLE_MAIN:     read_mux = interrupt_enable_main;
      ADDR_INTERRUPT_PRIORITY_MAIN:   read_mux = interrupt_priority_main;
      ADDR_INTERRUPT_ENABLE_KERNEL:   read_mux = interrupt_enable_kernel;
      ADDR_INTERRUPT_PRIORITY_KERNEL: read_mux = interrupt_priority_kernel;
      default:                        read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_sfr_rdata                 <= 8'h00;
      o_timer_zero_run            <= 1'b0;
      o_timer_one_run             <= 1'b0;
      o_merged_internal_request_n <= 1'b1;
    end
    else if (i_ce)
    begin
      if (i_sfr.rd)
        o_sfr_rdata <= read_mux;
      o_timer_zero_run            <= timer_run_overflow_control[BIT_TIMER_ZERO_RUN];
      o_timer_one_run             <= timer_run_overflow_control[BIT_TIMER_ONE_RUN];
      o_merged_internal_request_n <= !merged_internal_request;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  a_pin_vectors_unused:
    assert property (o_irq_req |-> (o_irq_vector != VEC_PIN_ZERO)
                                   && (o_irq_vector != VEC_PIN_ONE))
    else $error("pin interrupt vector entered");

  a_merged_or_level:
    assert property (i_ce && (|i_internal_src) |=> !o_merged_internal_request_n)
    else $error("merged request not active");

  a_kernel_vector:
    assert property (o_irq_req && (sel_idx == SRC_RTK) |-> o_irq_vector == VEC_KERNEL)
    else $error("kernel vector wrong");

  a_merged_delay:
    assert property (i_ce && delay_start && !soft_clear |=> !o_irq_req [*8])
    else $error("merged entry too early");

  a_fw_start_vec:
    assert property (o_fw_start |-> o_irq_vector == VEC_RESET && !o_irq_req)
    else $error("start vector wrong");

  a_usb_clear:
    assert property (i_ce && soft_clear |=> interrupt_enable_main == REG_RESET
                                           && timer_run_overflow_control == REG_RESET)
    else $error("usb reset did not clear");

  a_global_gate:
    assert property (!interrupt_enable_main[BIT_GLOBAL_IRQ_GATE] |-> src_req == '0)
    else $error("gate closed but request");

  a_reserved_zero:
    assert property ((interrupt_enable_main & ~MASK_ENABLE_MAIN) == 8'h00
                     && (interrupt_enable_kernel & ~MASK_KERNEL) == 8'h00)
    else $error("reserved enable bit set");

  a_flag_set:
    assert property (i_ce && i_timer_zero_ovf && !soft_clear |=> timer_zero_overflow_flag)
    else $error("overflow flag not set");

  a_preempt_only_hi:
    assert property ($rose(o_irq_req) && hi_active |-> 1'b0)
    else $error("request issued over high level");

endmodule

// file: tb/mic_cpu_model.sv
`timescale 1ns/1ps
module mic_cpu_model
(
  input  wire logic        i_clk,
  input  wire logic        i_irq_req,
  input  wire logic [15:0] i_irq_vector,
  output logic             o_irq_ack = 1'b0,
  output logic             o_reti = 1'b0,
  output logic [15:0]      o_taken_vec = 16'h0000
);
  // ----------
  // takes a vector at once, returns six cycles later
  // ----------
  int cnt = 0;
  always @(posedge i_clk)
  begin
    o_irq_ack <= i_irq_req && !o_irq_ack;
    o_reti    <= (cnt == 1);
    cnt       <= (cnt > 0) ? cnt - 1 : 0;
    if (i_irq_req && !o_irq_ack)
    begin
      o_taken_vec <= i_irq_vector;
      cnt         <= 6;
    end
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module tb;
  import mic_pkg::*;
  logic         clk = 1'b0, rstn = 1'b0, usb = 1'b0, frc = 1'b0, dl = 1'b0;
  logic         ov0 = 1'b0, ov1 = 1'b0, uart = 1'b0, krn = 1'b0;
  logic         ack, reti, req, fws, run0, run1, m_n;
  logic [7:0]   isrc = 8'h00, rdata;
  logic [15:0]  vec, tv;
  mic_sfr_req_s sfr = '0;
  int           err_total = 0, n_tests = 0, n0, n5;
  mic_core u_mic_core (.i_clk(clk), .i_resetn(rstn), .i_ce(1'b1), .i_sfr(sfr),
    .o_sfr_rdata(rdata), .i_usb_reset(usb), .i_function_reset_connect(frc),
    .i_download_done(dl), .i_timer_zero_ovf(ov0), .i_timer_one_ovf(ov1),
    .i_uart_req(uart), .i_internal_src(isrc), .i_kernel_req(krn), .i_irq_ack(ack),
    .i_reti(reti), .o_irq_req(req), .o_irq_vector(vec), .o_fw_start(fws),
    .o_timer_zero_run(run0), .o_timer_one_run(run1), .o_merged_internal_request_n(m_n));
  mic_cpu_model u_mic_cpu_model (.i_clk(clk), .i_irq_req(req), .i_irq_vector(vec),
    .o_irq_ack(ack), .o_reti(reti), .o_taken_vec(tv));
  // ----------
  // bus and timing helpers
  // ----------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) sfr <= '{a, 1'b1, 1'b0, d};
    @(posedge clk) sfr <= '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk) sfr <= '{a, 1'b0, 1'b1, 8'h00};
    @(posedge clk) sfr <= '0;
    @(posedge clk) #1;
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic lat(output int n);
    n = 0;
    do
    begin
      @(posedge clk) #1;
      n++;
    end
    while (req !== 1'b1 && n < 50);
    @(posedge clk) #1;
  endtask
  task automatic pulse_usb();
    @(posedge clk) usb <= 1'b1;
    @(posedge clk) usb <= 1'b0;
  endtask
  // ----------
  // scenarios
  // ----------
  task automatic s_regs();
    logic [7:0] ad [5] = '{8'h88, 8'ha8, 8'hb8, 8'he8, 8'hf8};
    logic [7:0] mk [5] = '{8'hf0, 8'hba, 8'h3a, 8'h01, 8'h01};
    for (int i = 0; i < 5; i++)
    begin
      rd(ad[i]);
      `CHK("reset", 8'h00, rdata)
      wr(ad[i], 8'hff);
      rd(ad[i]);
      `CHK("mask", mk[i], rdata)
    end
    `CHK("run", 2'b11, {run1, run0})
    rd(8'h90);
    `CHK("unmapped", 8'h00, rdata)
    pulse_usb();
    rd(8'ha8);
    `CHK("no_connect", 8'hba, rdata)
    @(posedge clk) frc <= 1'b1;
    pulse_usb();
    for (int i = 0; i < 5; i++)
    begin
      rd(ad[i]);
      `CHK("usb_clear", 8'h00, rdata)
    end
    `CHK("run_clear", 2'b00, {run1, run0})
  endtask
  task automatic s_start();
    @(posedge clk) dl <= 1'b1;
    for (int i = 0; i < 20 && fws !== 1'b1; i++)
      @(posedge clk) #1;
    `CHK("fw_start", 1'b1, fws)
    `CHK("fw_vec", 16'h2000, vec)
  endtask
  task automatic s_t0();
    @(posedge clk) ov0 <= 1'b1;
    @(posedge clk) ov0 <= 1'b0;
    wr(8'ha8, 8'h02);
    tick(6);
    `CHK("gate_off", 16'h0000, tv)
    rd(8'h88);
    `CHK("tf0_set", 8'h20, rdata)
    wr(8'ha8, 8'h82);
    lat(n0);
    `CHK("t0_vec", 16'h200b, tv)
    tick(8);
    rd(8'h88);
    `CHK("tf0_clr", 8'h00, rdata)
  endtask
  task automatic s_merged();
    @(posedge clk) isrc <= 8'h40;
    tick(2);
    `CHK("merged_low", 1'b0, m_n)
    wr(8'ha8, 8'ha0);
    lat(n5);
    @(posedge clk) isrc <= 8'h00;
    `CHK("entry_delay", 8, n5 - n0)
    `CHK("merged_vec", 16'h202b, tv)
    tick(3);
    `CHK("merged_high", 1'b1, m_n)
    tick(6);
  endtask
  task automatic s_prio();
    wr(8'hb8, 8'h10);
    @(posedge clk) uart <= 1'b1;
    @(posedge clk) ov0 <= 1'b1;
    @(posedge clk) ov0 <= 1'b0;
    wr(8'ha8, 8'h92);
    lat(n0);
    `CHK("hi_first", 16'h2023, tv)
    @(posedge clk) uart <= 1'b0;
    lat(n0);
    `CHK("lo_next", 16'h200b, tv)
    tick(8);
  endtask
  task automatic s_t1();
    @(posedge clk) ov1 <= 1'b1;
    @(posedge clk) ov1 <= 1'b0;
    wr(8'ha8, 8'h88);
    lat(n0);
    `CHK("t1_vec", 16'h201b, tv)
    tick(8);
    rd(8'h88);
    `CHK("tf1_clr", 8'h00, rdata)
  endtask
  task automatic s_kernel();
    wr(8'ha8, 8'h80);
    wr(8'he8, 8'h01);
    @(posedge clk) krn <= 1'b1;
    lat(n0);
    `CHK("rtk_vec", 16'h2033, tv)
    @(posedge clk) krn <= 1'b0;
  endtask
  task automatic report_and_stop();
    if (err_total == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
    forever #5 clk = ~clk;
  initial
  begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    s_regs();
    s_start();
    s_t0();
    s_merged();
    s_prio();
    s_t1();
    s_kernel();
    report_and_stop();
  end
  initial
  begin
    #50us;
    err_total++;
    report_and_stop();
  end
endmodule
